// File: hdl/lcd_instruction_executor.v
// instruction decode and execution for a character dot-matrix lcd controller
// assumes a host shifting 10-bit frames (select high, select low, data 7..0)
// on link_clk rising edges; link pins are asynchronous to clk
//
// Summary of operation
// - instruction 0001xxxx moves cursor or display only
// - target bit picks cursor/display, direction bit picks right
// - display shift leaves address counter unchanged
// - two-line cursor wraps line one into two
// - blink style picks inverted or all-dots blink
// - line count bit; two lines force 5x7, duty
// - one-line font bit picks 5x10 or 5x7
// - test bit enters test mode; host writes zero
// - 01xxxxxx loads glyph memory address into counter
// - 1xxxxxxx loads display memory address into counter
// - data write goes to last addressed memory
// - data write steps counter, applies entry shift to display memory writes only
// - select 10 stores first led register
// - select 11 stores second led register
// - commands arriving while busy are ignored
// - data write finishes within 46 us
`timescale 1ns/100ps
`include "lcd_exec_map.vh"
module lcd_instruction_executor (
  input  wire       clk,
  input  wire       nrst,
  input  wire       ce,
  input  wire       link_clk,
  input  wire       link_data,
  output wire       busy,
  output reg        cmd_dropped_q,
  output reg  [6:0] address_counter_q,
  output reg  [6:0] shift_offset_q,
  output reg        target_glyph_q,
  output reg        mem_we_q,
  output reg        mem_glyph_q,
  output reg  [6:0] mem_addr_q,
  output reg  [7:0] mem_wdata_q,
  output reg        blink_style_q,
  output reg        two_line_q,
  output reg        font_tall_q,
  output reg  [1:0] duty_q,
  output reg        test_mode_q,
  output reg        entry_up_q,
  output reg        entry_shift_q,
  output reg        display_on_q,
  output reg        cursor_on_q,
  output reg        blink_on_q,
  output reg  [7:0] led_row_one_register_q,
  output reg  [7:0] led_row_two_register_q
);

  // link synchronisers: stage 0 is read only by stage 1
  reg  [1:0] sck_sync_q;      // link clock, two flip-flops
  reg  [1:0] sid_sync_q;      // link data, two flip-flops
  reg        sck_prev_q;      // settled link clock one cycle back
  reg  [9:0] frame_q;         // assembled frame, select bits on top
  reg  [3:0] bit_cnt_q;       // bits taken in the current frame
  reg        word_ready_q;    // frame complete, one-cycle pulse
  wire       sck_rise;        // rising edge of the settled link clock

  // oscillator emulation
  reg  [8:0] osc_cnt_q;       // divides clk down to the oscillator rate
  reg        osc_tick_q;      // one pulse per oscillator cycle

  // clear sweep
  reg        clearing_q;      // display memory fill in progress
  reg  [6:0] clear_idx_q;     // fill position, 0 to 79

  // decode results
  wire [1:0] rsel;            // register select pair of the frame
  wire [7:0] cmd;             // data byte of the frame
  wire       take;            // frame accepted this cycle
  reg  [8:0] ticks_d;         // working time of the accepted command
  reg        load_d;          // start the busy timer
  wire       timer_busy;      // busy from the timer
  // counts held at 32 bits so the 9-bit timer load is cut on purpose
  localparam [31:0] TK_INSTR_W = `TK_INSTR;   // instruction working time
  localparam [31:0] TK_WRITE_W = `TK_WRITE;   // data write working time
  localparam [31:0] TK_CLEAR_W = `TK_CLEAR;   // clear and home working time

  assign sck_rise = sck_sync_q[1] & ~sck_prev_q;
  assign rsel     = frame_q[`FRAME_RS_HI:`FRAME_RS_LO];
  assign cmd      = frame_q[7:0];
  assign busy     = timer_busy;
  // a frame landing while busy is thrown away, never queued
  assign take     = word_ready_q & ~timer_busy & ~clearing_q;

  // next address after a step; glyph addresses wrap in six bits
  function [6:0] step_addr;
    input [6:0] a;
    input       up;
    input       two;
    input       glyph;
    begin
      if (glyph) begin
        if (up)
          step_addr = {1'b0, a[5:0] + 6'h01};
        else
          step_addr = {1'b0, a[5:0] - 6'h01};
      end else if (two) begin
        // line one end carries into line two start
        if (up)
          step_addr = (a == `DD_L1_LAST) ? `DD_L2_FIRST :
                      (a == `DD_L2_LAST) ? 7'h00 : a + 7'h01;
        else
          step_addr = (a == `DD_L2_FIRST) ? `DD_L1_LAST :
                      (a == 7'h00) ? `DD_L2_LAST : a - 7'h01;
      end else begin
        if (up)
          step_addr = (a == `DD_ONE_LAST) ? 7'h00 : a + 7'h01;
        else
          step_addr = (a == 7'h00) ? `DD_ONE_LAST : a - 7'h01;
      end
    end
  endfunction

  // next display offset; both lines share one offset, horizontal only
  function [6:0] shift_ofs;
    input [6:0] o;
    input       left;
    input       two;
    reg   [6:0] lim;
    begin
      lim = two ? `OFS_TWO_LAST : `OFS_ONE_LAST;
      if (left)
        shift_ofs = (o == lim) ? 7'h00 : o + 7'h01;
      else
        shift_ofs = (o == 7'h00) ? lim : o - 7'h01;
    end
  endfunction

  // link sampling: edges found only on the second synchroniser stage
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_sync_q   <= 2'h0;
      sid_sync_q   <= 2'h0;
      sck_prev_q   <= 1'b0;
      frame_q      <= 10'h000;
      bit_cnt_q    <= 4'h0;
      word_ready_q <= 1'b0;
    end else if (ce) begin
      sck_sync_q   <= {sck_sync_q[0], link_clk};
      sid_sync_q   <= {sid_sync_q[0], link_data};
      sck_prev_q   <= sck_sync_q[1];
      word_ready_q <= 1'b0;
      if (sck_rise) begin
        frame_q <= {frame_q[8:0], sid_sync_q[1]};
        // tenth bit closes the frame
        if (bit_cnt_q == `FRAME_LAST) begin
          bit_cnt_q    <= 4'h0;
          word_ready_q <= 1'b1;
        end else begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end
    end
  end

  // oscillator tick: busy time is counted in these, not in clk cycles
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_cnt_q  <= 9'h000;
      osc_tick_q <= 1'b0;
    end else if (ce) begin
      if (osc_cnt_q == `OSC_DIV - 1) begin
        osc_cnt_q  <= 9'h000;
        osc_tick_q <= 1'b1;
      end else begin
        osc_cnt_q  <= osc_cnt_q + 9'h001;
        osc_tick_q <= 1'b0;
      end
    end
  end

  // working time of the accepted frame
  always @* begin
    load_d  = 1'b0;
    ticks_d = 9'h000;
    if (take) begin
      load_d = 1'b1;
      case (rsel)
        `RS_INSTR: begin
          // clear and home take the long time, a zero byte none, the rest the short one
          if (cmd[7:2] == 6'h00 && cmd[1:0] != 2'h0)
            ticks_d = TK_CLEAR_W[8:0];
          else if (cmd != 8'h00)
            ticks_d = TK_INSTR_W[8:0];
        end
        // write is bounded by the rounded-down 46 us count
        `RS_DATA:  ticks_d = TK_WRITE_W[8:0];
        // led writes have no working time
        default:   ticks_d = 9'h000;
      endcase
    end
  end

  // busy from acceptance until the tick count runs out
  // power-up busy spans one instruction time, ample for the 80-cycle sweep
  exec_timer #(
    .RESET_COUNT (TK_INSTR_W[8:0])
  ) u_timer (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .osc_tick (osc_tick_q),
    .load     (load_d),
    .ticks    (ticks_d),
    .busy_q   (timer_busy)
  );

  // executor state: reset leaves the chip as if clear, function set,
  // entry mode and display off had run
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_dropped_q          <= 1'b0;
      address_counter_q      <= 7'h00;
      shift_offset_q         <= 7'h00;
      target_glyph_q         <= 1'b0;
      mem_we_q               <= 1'b0;
      mem_glyph_q            <= 1'b0;
      mem_addr_q             <= 7'h00;
      mem_wdata_q            <= 8'h00;
      blink_style_q          <= `RST_BLINK_STYLE;
      two_line_q             <= 1'b0;
      font_tall_q            <= 1'b0;
      duty_q                 <= `DUTY_8;
      test_mode_q            <= 1'b0;
      entry_up_q             <= `RST_ENTRY_UP;
      entry_shift_q          <= 1'b0;
      display_on_q           <= 1'b0;
      cursor_on_q            <= 1'b0;
      blink_on_q             <= 1'b0;
      led_row_one_register_q <= 8'h00;
      led_row_two_register_q <= 8'h00;
      clearing_q             <= 1'b1;
      clear_idx_q            <= 7'h00;
    end else if (ce) begin
      mem_we_q      <= 1'b0;
      // frames refused because of busy are flagged for one cycle
      cmd_dropped_q <= word_ready_q & ~take;
      if (clearing_q) begin
        // one space per cycle; second line sits at its own base
        mem_we_q    <= 1'b1;
        mem_glyph_q <= 1'b0;
        mem_wdata_q <= `SPACE_CODE;
        if (two_line_q && clear_idx_q > `OFS_TWO_LAST)
          mem_addr_q <= clear_idx_q + `DD_L2_SKEW;
        else
          mem_addr_q <= clear_idx_q;
        if (clear_idx_q == `CLEAR_LAST) begin
          clearing_q  <= 1'b0;
          clear_idx_q <= 7'h00;
        end else begin
          clear_idx_q <= clear_idx_q + 7'h01;
        end
      end else if (take) begin
        case (rsel)
          `RS_INSTR: begin
            // highest set bit picks the command; lower bits are don't-care
            if (cmd[`BIT_DISP_ADDR]) begin
              address_counter_q <= cmd[6:0];
              target_glyph_q    <= 1'b0;
            end else if (cmd[`BIT_GLYPH_ADDR]) begin
              address_counter_q <= {1'b0, cmd[5:0]};
              target_glyph_q    <= 1'b1;
            end else if (cmd[`BIT_FUNC_SET]) begin
              blink_style_q <= cmd[`F_BLINK_STYLE];
              two_line_q    <= cmd[`F_TWO_LINE];
              // two lines force the short font
              font_tall_q   <= cmd[`F_FONT_TALL] & ~cmd[`F_TWO_LINE];
              if (cmd[`F_TWO_LINE])
                duty_q <= `DUTY_16;
              else if (cmd[`F_FONT_TALL])
                duty_q <= `DUTY_11;
              else
                duty_q <= `DUTY_8;
              // test mode is honoured; normal hosts write zero here
              test_mode_q   <= cmd[`F_TEST_MODE];
            end else if (cmd[`BIT_SHIFT]) begin
              // memory contents untouched, no write strobe here
              if (cmd[`F_SHIFT_TARGET])
                // whole display moves, counter kept
                shift_offset_q <= shift_ofs(shift_offset_q,
                                            ~cmd[`F_SHIFT_RIGHT], two_line_q);
              else
                // cursor moves, right when the direction bit is set
                address_counter_q <= step_addr(address_counter_q,
                                               cmd[`F_SHIFT_RIGHT], two_line_q,
                                               target_glyph_q);
            end else if (cmd[`BIT_DISP_CTL]) begin
              display_on_q <= cmd[`F_DISP_ON];
              cursor_on_q  <= cmd[`F_CURSOR_ON];
              blink_on_q   <= cmd[`F_BLINK_ON];
            end else if (cmd[`BIT_ENTRY]) begin
              entry_up_q    <= cmd[`F_ENTRY_UP];
              entry_shift_q <= cmd[`F_ENTRY_SHIFT];
            end else if (cmd[`BIT_HOME]) begin
              // home: counter and shift return, memory kept
              address_counter_q <= 7'h00;
              shift_offset_q    <= 7'h00;
              target_glyph_q    <= 1'b0;
            end else if (cmd[`BIT_CLEAR]) begin
              // clear: fill with spaces, home, entry forced to increment
              address_counter_q <= 7'h00;
              shift_offset_q    <= 7'h00;
              target_glyph_q    <= 1'b0;
              entry_up_q        <= 1'b1;
              clearing_q        <= 1'b1;
            end
          end
          `RS_DATA: begin
            // store into whichever memory was addressed last
            mem_we_q          <= 1'b1;
            mem_glyph_q       <= target_glyph_q;
            mem_addr_q        <= address_counter_q;
            mem_wdata_q       <= cmd;
            // step in the entry direction
            address_counter_q <= step_addr(address_counter_q, entry_up_q,
                                           two_line_q, target_glyph_q);
            // entry shift moves the display opposite the cursor step
            if (entry_shift_q && !target_glyph_q)
              shift_offset_q <= shift_ofs(shift_offset_q, entry_up_q, two_line_q);
          end
          `RS_LED_ONE: led_row_one_register_q <= cmd;
          `RS_LED_TWO: led_row_two_register_q <= cmd;
          default: led_row_one_register_q <= led_row_one_register_q;
        endcase
      end
    end
  end

endmodule

// File: include/lcd_exec_map.vh
// constants for the lcd instruction executor: field positions, codes, timing
// assumes it is included by bare name from every file that needs it
`ifndef LCD_EXEC_MAP_VH
`define LCD_EXEC_MAP_VH

// frame layout: register select high first, then data bit 7 down to bit 0
`define FRAME_BITS      4'hA
`define FRAME_LAST      4'h9
`define FRAME_RS_HI     9
`define FRAME_RS_LO     8

// register select codes
`define RS_INSTR        2'h0
`define RS_DATA         2'h1
`define RS_LED_ONE      2'h2
`define RS_LED_TWO      2'h3

// instruction decode bit positions, highest set bit picks the command
`define BIT_DISP_ADDR   7
`define BIT_GLYPH_ADDR  6
`define BIT_FUNC_SET    5
`define BIT_SHIFT       4
`define BIT_DISP_CTL    3
`define BIT_ENTRY       2
`define BIT_HOME        1
`define BIT_CLEAR       0

// field positions inside commands
`define F_SHIFT_TARGET  3
`define F_SHIFT_RIGHT   2
`define F_BLINK_STYLE   4
`define F_TWO_LINE      3
`define F_FONT_TALL     2
`define F_TEST_MODE     1
`define F_DISP_ON       2
`define F_CURSOR_ON     1
`define F_BLINK_ON      0
`define F_ENTRY_UP      1
`define F_ENTRY_SHIFT   0

// display memory address layout
`define DD_ONE_LAST     7'h4F
`define DD_L1_LAST      7'h27
`define DD_L2_FIRST     7'h40
`define DD_L2_LAST      7'h67
`define DD_L2_SKEW      7'h18
`define OFS_ONE_LAST    7'h4F
`define OFS_TWO_LAST    7'h27
`define CLEAR_LAST      7'h4F
`define SPACE_CODE      8'h20

// duty encodings
`define DUTY_8          2'h0
`define DUTY_11         2'h1
`define DUTY_16         2'h2

// reset values of the mode bits (reset runs clear, function set, entry, display off)
`define RST_BLINK_STYLE 1'b1
`define RST_ENTRY_UP    1'b1

// timing: clock and oscillator rates, working times in ns
`define CLK_KHZ         100000
`define OSC_KHZ         250
`define OSC_DIV         (`CLK_KHZ / `OSC_KHZ)
`define T_INSTR_NS      40000
`define T_WRITE_NS      46000
`define T_CLEAR_NS      1640000
// longest times, so oscillator tick counts round down
`define TK_INSTR        (`T_INSTR_NS * `OSC_KHZ / 1000000)
`define TK_WRITE        (`T_WRITE_NS * `OSC_KHZ / 1000000)
`define TK_CLEAR        (`T_CLEAR_NS * `OSC_KHZ / 1000000)

`endif

// File: hdl/exec_timer.v
// busy timer counting oscillator ticks from command acceptance
// assumes osc_tick is a one-cycle pulse on clk and load is never given while busy
`timescale 1ns/100ps
module exec_timer #(
  parameter [8:0] RESET_COUNT = 9'h000
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire       ce,
  input  wire       osc_tick,
  input  wire       load,
  input  wire [8:0] ticks,
  output reg        busy_q
);

  reg [8:0] count_q;   // remaining oscillator ticks

  // load starts the count, each oscillator tick takes one away
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= RESET_COUNT;
      busy_q  <= (RESET_COUNT != 9'h000);
    end else if (ce) begin
      if (load) begin
        count_q <= ticks;
        busy_q  <= (ticks != 9'h000);
      end else if (osc_tick && count_q != 9'h000) begin
        count_q <= count_q - 9'h001;
        // busy drops with the last tick, not one cycle later
        busy_q  <= (count_q != 9'h001);
      end
    end
  end

endmodule

// File: tb/lcd_exec_sva.sv
// checker for the lcd instruction executor, watching its top ports only
// assumes it is bound into lcd_instruction_executor and runs on clk with nrst
`timescale 1ns/100ps
module lcd_exec_sva (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       busy,
  input wire logic       cmd_dropped_q,
  input wire logic [6:0] address_counter_q,
  input wire logic [6:0] shift_offset_q,
  input wire logic       target_glyph_q,
  input wire logic       mem_we_q,
  input wire logic       mem_glyph_q,
  input wire logic [6:0] mem_addr_q,
  input wire logic       two_line_q,
  input wire logic       font_tall_q,
  input wire logic [1:0] duty_q,
  input wire logic       entry_up_q,
  input wire logic [7:0] led_row_one_register_q,
  input wire logic [7:0] led_row_two_register_q
);
  logic [17:0] busy_len_q;   // cycles the current busy span has lasted
  logic        wr_run_q;     // span began with a memory write

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // span length counter; the reset span counts from release, hence one spare cycle below
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_len_q <= 18'h00000;
      wr_run_q   <= 1'b0;
    end else if (busy) begin
      busy_len_q <= busy_len_q + 18'h00001;
      wr_run_q   <= (busy_len_q == 18'h00000) ? mem_we_q : wr_run_q;
    end else begin
      busy_len_q <= 18'h00000;
    end
  end

  // a host data write lands on the edge that raises busy
  sequence s_write_start;
    mem_we_q && $rose(busy);
  endsequence
  sequence s_busy_end;
    $fell(busy);
  endsequence

  a_drop_pulse_once: assert property (cmd_dropped_q |=> !cmd_dropped_q)
    else $error("drop flag held past one cycle");
  a_drop_only_busy: assert property (cmd_dropped_q |-> $past(busy))
    else $error("frame dropped while idle");
  a_duty_code: assert property ($stable(two_line_q) && $stable(font_tall_q) |->
    duty_q == (two_line_q ? 2'h2 : {1'b0, font_tall_q}))
    else $error("duty does not match line count and font");
  a_write_step: assert property (s_write_start ##0
    !(mem_addr_q inside {7'h00, 7'h27, 7'h3F, 7'h40, 7'h4F, 7'h67}) |->
    address_counter_q == (entry_up_q ? mem_addr_q + 7'h01 : mem_addr_q - 7'h01))
    else $error("counter not stepped by one after write");
  a_write_target: assert property (s_write_start |-> mem_glyph_q == target_glyph_q)
    else $error("write went to the wrong memory");
  a_write_pulse: assert property (s_write_start |=> !mem_we_q [*8])
    else $error("extra write strobe after a data write");
  a_write_span: assert property (s_busy_end ##0 wr_run_q |->
    busy_len_q >= 4001 && busy_len_q <= 4400)
    else $error("data write busy span out of range");
  a_busy_span: assert property (s_busy_end |-> busy_len_q >= 3601 && busy_len_q <= 164001)
    else $error("busy span out of range");
  a_shift_keeps_ac: assert property (!$stable(shift_offset_q) && !mem_we_q &&
    shift_offset_q != 7'h00 |-> $stable(address_counter_q))
    else $error("display shift moved the counter");
  a_led_idle: assert property (!$stable(led_row_one_register_q) ||
    !$stable(led_row_two_register_q) |-> !busy && !$past(busy))
    else $error("led register changed around busy");
endmodule

// File: tb/host_link_model.sv
// host side of the serial command link: shifts 10-bit frames, select bits first
// assumes the caller keeps to one frame at a time; clock rests low between frames
`timescale 1ns/100ps
module host_link_model (
  input  wire logic busy,       // executor busy, polled before each frame unless rude
  output logic      link_clk,   // serial clock, 125 ns period inside frames
  output logic      link_data   // serial data, set up half a period before each rise
);
  initial begin
    link_clk  = 1'b0;
    link_data = 1'b1;
  end

  // one frame; a real host waits out busy, a rude one does not
  task send_frame(input logic [9:0] f, input logic rude);
    integer i;
    begin
      if (!rude) wait (busy === 1'b0);
      for (i = 9; i >= 0; i = i - 1) begin
        link_data = f[i];
        #62.5 link_clk = 1'b1;
        #62.5 link_clk = 1'b0;
      end
      link_data = ~f[0];   // released line shows no stale value
      #62.5;               // idle gap, so a following frame never lands in this time step
    end
  endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the lcd instruction executor
// assumes the host link model drives the pins; power-up busy lasts one instruction time
`timescale 1ns/100ps
module testbench;
  logic       clk, nrst, ce;     // system clock, reset, enable held high
  wire        link_clk, link_data, busy, cmd_dropped_q, target_glyph_q, mem_we_q;
  wire        mem_glyph_q, blink_style_q, two_line_q, font_tall_q, test_mode_q;
  wire        entry_up_q, entry_shift_q, display_on_q, cursor_on_q, blink_on_q;
  wire [1:0]  duty_q;
  wire [6:0]  address_counter_q, shift_offset_q, mem_addr_q;
  wire [7:0]  mem_wdata_q, led_row_one_register_q, led_row_two_register_q;
  integer     miscompares, check_count;

  lcd_instruction_executor lcd_instruction_executor_i (
    .clk, .nrst, .ce, .link_clk, .link_data, .busy, .cmd_dropped_q, .address_counter_q,
    .shift_offset_q, .target_glyph_q, .mem_we_q, .mem_glyph_q, .mem_addr_q, .mem_wdata_q,
    .blink_style_q, .two_line_q, .font_tall_q, .duty_q, .test_mode_q, .entry_up_q,
    .entry_shift_q, .display_on_q, .cursor_on_q, .blink_on_q, .led_row_one_register_q,
    .led_row_two_register_q
  );
  host_link_model host_link_model_i (.busy, .link_clk, .link_data);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
    end
  endtask

  task test_done;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask

  // instruction frame, then let its effects land
  task ins(input logic [7:0] d);
    begin
      host_link_model_i.send_frame({2'h0, d}, 1'b0);
      repeat (10) @(negedge clk);
    end
  endtask

  // data write; the strobe is watched while the frame is still shifting
  task wr(input logic [7:0] b, input logic [6:0] a, input logic g);
    integer n;
    begin
      fork
        host_link_model_i.send_frame({2'h1, b}, 1'b0);
        for (n = 0; n < 6000 && mem_we_q !== 1'b1; n = n + 1) @(negedge clk);
      join
      chk(n < 6000, 8'h01, "write strobe");
      chk(mem_addr_q, a, "write address");
      chk(mem_wdata_q, b, "write data");
      chk(mem_glyph_q, g, "write memory");
      for (n = 0; n < 5000 && busy !== 1'b0; n = n + 1) @(negedge clk);
      chk(n <= 4400, 8'h01, "write time");
    end
  endtask

  // all line/font pairs, blink style toggled, don't-care bit set on odd passes
  task t_func;
    integer i;
    logic   bl, n, f;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        bl = ~i[0];
        n  = i[1];
        f  = i[0] ^ i[1];
        ins({3'h1, bl, n, f, 1'b0, i[0]});
        chk(blink_style_q, bl, "blink style");
        chk(two_line_q, n, "line count");
        chk(duty_q, n ? 8'h02 : {7'h00, f}, "duty");
        chk(font_tall_q, f & ~n, "font");
      end
      ins(8'h3A);
      chk(test_mode_q, 8'h01, "test mode on");
      ins(8'h28);
      chk(test_mode_q, 8'h00, "test mode off");
    end
  endtask

  // led frame pushed in while an instruction still runs
  task t_drop;
    integer n;
    begin
      ins(8'h0C);
      chk({display_on_q, cursor_on_q, blink_on_q}, 8'h04, "display control");
      fork
        host_link_model_i.send_frame({2'h2, 8'hA5}, 1'b1);
        for (n = 0; n < 400 && cmd_dropped_q !== 1'b1; n = n + 1) @(negedge clk);
      join
      chk(n < 400, 8'h01, "drop flag");
      chk(led_row_one_register_q, 8'h00, "led kept");
    end
  endtask

  // two-line cursor wrap and display shifts, then a glyph address
  task t_shift;
    begin
      ins(8'hA7);
      chk(address_counter_q, 8'h27, "display address");
      chk(target_glyph_q, 8'h00, "display target");
      ins(8'h14);
      chk(address_counter_q, 8'h40, "cursor right wrap");
      ins(8'h13);
      chk(address_counter_q, 8'h27, "cursor left");
      ins(8'h18);
      chk(shift_offset_q, 8'h01, "display left");
      chk(address_counter_q, 8'h27, "counter kept");
      ins(8'h1C);
      chk(shift_offset_q, 8'h00, "display right");
      ins(8'h7F);
      chk(address_counter_q, 8'h3F, "glyph address");
      chk(target_glyph_q, 8'h01, "glyph target");
    end
  endtask

  // writes with increment, decrement, entry shift and a glyph target
  task t_write;
    begin
      ins(8'h85);
      wr(8'h41, 7'h05, 1'b0);
      chk(address_counter_q, 8'h06, "step up");
      ins(8'h04);
      wr(8'h42, 7'h06, 1'b0);
      chk(address_counter_q, 8'h05, "step down");
      ins(8'h07);
      chk({entry_up_q, entry_shift_q}, 8'h03, "entry mode");
      wr(8'h43, 7'h05, 1'b0);
      chk(shift_offset_q, 8'h01, "entry shift");
      ins(8'h50);
      wr(8'h1F, 7'h10, 1'b1);
      chk(address_counter_q, 8'h11, "glyph step");
    end
  endtask

  // led frames back to back, no busy between them
  task t_led;
    begin
      host_link_model_i.send_frame({2'h2, 8'h5A}, 1'b0);
      host_link_model_i.send_frame({2'h3, 8'hC3}, 1'b0);
      repeat (10) @(negedge clk);
      chk(led_row_one_register_q, 8'h5A, "led one");
      chk(led_row_two_register_q, 8'hC3, "led two");
      chk(busy, 8'h00, "led no busy");
    end
  endtask

  // main sequence: reset, wait out the power-up sweep, then the scenarios
  initial begin
    miscompares = 0;
    check_count = 0;
    nrst = 1'b0;
    ce   = 1'b1;
    repeat (10) @(negedge clk);
    chk(blink_style_q, 8'h01, "blink style reset");
    nrst = 1'b1;
    wait (busy === 1'b0);
    t_func;
    t_drop;
    t_shift;
    t_write;
    t_led;
    test_done;
  end

  // watchdog; about 20 commands of at most 4400 cycles each, plus margin
  initial begin
    #1100000;
    miscompares = miscompares + 1;
    test_done;
  end
endmodule

bind lcd_instruction_executor lcd_exec_sva lcd_exec_sva_i (
  .clk, .nrst, .busy, .cmd_dropped_q, .address_counter_q, .shift_offset_q, .target_glyph_q,
  .mem_we_q, .mem_glyph_q, .mem_addr_q, .two_line_q, .font_tall_q, .duty_q, .entry_up_q,
  .led_row_one_register_q, .led_row_two_register_q
);
